//--- inc/swfcr_pkg.sv
package swfcr_pkg;

  // register offsets in configuration space
  localparam logic [7:0] OFF_ACK_LAT    = 8'h70;
  localparam logic [7:0] OFF_SW_MODE    = 8'h74;

  // ack latency control fields
  localparam int ACK_VAL_LSB            = 16;
  localparam int ACK_VAL_W              = 14;
  localparam int ACK_EN_BIT             = 30;
  localparam int VGA_BIT                = 31;
  localparam logic [13:0] ACK_VAL_RST   = 14'h0000;
  localparam logic        ACK_EN_RST    = 1'h0;
  localparam logic        VGA_RST       = 1'h1;

  // switch mode fields
  localparam int SF_BIT                 = 0;
  localparam int THR_LSB                = 1;
  localparam int ARB_BIT                = 3;
  localparam int CRD_BIT                = 4;
  localparam int ORD_EGR_BIT            = 5;
  localparam int ORD_TAG_BIT            = 6;
  localparam int MODE_W                 = 7;
  localparam logic [1:0] THR_RST        = 2'h1;
  localparam logic [6:0] MODE_RST       = 7'h02;

  // register update source: none, default load or software write
  typedef enum logic [2:0] {
    SRC_NONE = 3'h1,
    SRC_SIDE = 3'h2,
    SRC_CFG  = 3'h4
  } swfcr_src_t;

endpackage : swfcr_pkg

//--- src/swfcr_ack_sel.sv
`timescale 1ns/1ps
`default_nettype none

// chooses the acknowledge latency in use
module swfcr_ack_sel #(
  parameter int W = 14
) (
  // user override
  input  wire logic [W-1:0] user_val,
  input  wire logic         user_en,
  // built-in default for the current link
  input  wire logic [W-1:0] builtin_val,
  // selected latency
  output logic      [W-1:0] ack_latency
);

  // override replaces built-in value
  always_comb begin
    ack_latency = user_en ? user_val : builtin_val; // see RL2, see RL15
  end

endmodule : swfcr_ack_sel
`default_nettype wire

//--- src/swfcr_thr_calc.sv
`timescale 1ns/1ps
`default_nettype none

// cut-through start point from packet length and threshold code
module swfcr_thr_calc #(
  parameter int LW = 11
) (
  // packet length in cycles
  input  wire logic [LW-1:0] pkt_len,
  input  wire logic [1:0]    thr_sel,
  // cycle at which forwarding may start
  output logic      [LW-1:0] start_cycle
);

  logic [LW-1:0] mid;

  // midpoint minus 0..3 cycles, floored at zero
  always_comb begin
    mid = pkt_len >> 1;
    if (mid > LW'(thr_sel)) begin
      start_cycle = mid - LW'(thr_sel); // see RL8
    end else begin
      start_cycle = '0;
    end
  end

endmodule : swfcr_thr_calc
`default_nettype wire

//--- src/swfcr_regs.sv
// Behaviour
// RL1: 14-bit user ack latency in bits 29:16, read-write, resets to zero.
// RL2: bit 30 set makes the user ack latency replace the built-in one.
// RL3: bit 31 read-only VGA decode enable flag, resets to one.
// RL4: defaults replaceable through side port or serial EEPROM auto-load.
// RL5: switch mode register exists only on the upstream port, offset 74h.
// RL6: bit 0 set store-and-forward, clear (reset) cut-through.
// RL7: bits 2:1 set cut-through threshold for slow-to-fast forwarding.
// RL8: 00b midpoint, 01b/10b/11b 1/2/3 cycles ahead; reset 01b.
// RL9: bit 3 set keeps arbiter on pending port despite short credit.
// RL10: bit 3 clear moves arbiter only to requesters with enough credit.
// RL11: bit 4 set releases credit for all types per update.
// RL12: bit 4 clear releases credit per type per update.
// RL13: bit 5 set enforces ordering across different egress ports; reset 0.
// RL14: bit 6 set enforces ordering between completions of different tags.
// RL15: with override off, use built-in latency for link width and speed.
`timescale 1ns/1ps
`default_nettype none

module swfcr_regs #(
  parameter bit  UPSTREAM = 1'b1,
  parameter int  NPORT    = 6,
  parameter int  LW       = 11
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             rst,
  // configuration access
  input  wire logic             cfg_wr,
  input  wire logic             cfg_rd,
  input  wire logic [7:0]       cfg_addr,
  input  wire logic [3:0]       cfg_be,
  input  wire logic [31:0]      cfg_wdata,
  output logic      [31:0]      cfg_rdata,
  output logic                  cfg_hit,
  // default load from side port or eeprom
  input  wire logic             ld_valid,
  input  wire logic [7:0]       ld_addr,
  input  wire logic [31:0]      ld_data,
  // built-in ack latency for current link
  input  wire logic [13:0]      builtin_ack,
  // arbitration inputs
  input  wire logic [NPORT-1:0] arb_req,
  input  wire logic [NPORT-1:0] arb_credit_ok,
  input  wire logic             arb_advance,
  // cut-through inputs
  input  wire logic [LW-1:0]    pkt_len,
  input  wire logic             slow_to_fast,
  // mode outputs
  output logic      [13:0]      ack_latency,
  output logic                  vga_decode_en,
  output logic                  store_forward,
  output logic      [LW-1:0]    ct_start_cycle,
  output logic      [NPORT-1:0] arb_grant,
  output logic                  credit_all_types,
  output logic                  order_egress,
  output logic                  order_cpl_tag
);

  ////////////////////////////////////////////////////////////////////////////
  logic [13:0]       ack_val, next_ack_val;
  logic              ack_en, next_ack_en;
  logic              vga, next_vga;
  logic [6:0]        mode, next_mode;
  logic [NPORT-1:0]  grant, next_grant;
  logic [31:0]       ack_word, mode_word, wmask, next_rdata;
  logic              next_hit;
  logic [LW-1:0]     ct_raw;
  swfcr_pkg::swfcr_src_t src;

  // byte enables to bit mask
  function automatic logic [31:0] be_mask(input logic [3:0] be);
    be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : be_mask

  // register presence decode
  function automatic logic is_mode(input logic [7:0] a);
    is_mode = UPSTREAM && (a == swfcr_pkg::OFF_SW_MODE); // see RL5
  endfunction : is_mode

  assign wmask = be_mask(cfg_be);

  // packed read views
  always_comb begin
    ack_word = '0;
    ack_word[swfcr_pkg::ACK_VAL_LSB +: swfcr_pkg::ACK_VAL_W] = ack_val;
    ack_word[swfcr_pkg::ACK_EN_BIT] = ack_en;
    ack_word[swfcr_pkg::VGA_BIT]    = vga;
    mode_word = '0;
    mode_word[swfcr_pkg::MODE_W-1:0] = mode;
  end

  ////////////////////////////////////////////////////////////////////////////
  // register next values: load port overrides software in the same cycle
  always_comb begin
    next_ack_val = ack_val;
    next_ack_en  = ack_en;
    next_vga     = vga;
    next_mode    = mode;
    src          = swfcr_pkg::SRC_NONE;
    if (ld_valid) begin
      src = swfcr_pkg::SRC_SIDE;
    end else if (cfg_wr) begin
      src = swfcr_pkg::SRC_CFG;
    end
    case (src)
      swfcr_pkg::SRC_SIDE: begin
        // full-word default replacement, read-only bits included
        if (ld_addr == swfcr_pkg::OFF_ACK_LAT) begin
          next_ack_val = ld_data[swfcr_pkg::ACK_VAL_LSB +: swfcr_pkg::ACK_VAL_W]; // see RL4
          next_ack_en  = ld_data[swfcr_pkg::ACK_EN_BIT]; // see RL4
          next_vga     = ld_data[swfcr_pkg::VGA_BIT]; // see RL4, see RL3
        end else if (is_mode(ld_addr)) begin
          next_mode = ld_data[swfcr_pkg::MODE_W-1:0]; // see RL4
        end
      end
      swfcr_pkg::SRC_CFG: begin
        if (cfg_addr == swfcr_pkg::OFF_ACK_LAT) begin
          // vga flag is read-only to software
          next_ack_val = (ack_word[swfcr_pkg::ACK_VAL_LSB +: swfcr_pkg::ACK_VAL_W]
                          & ~wmask[swfcr_pkg::ACK_VAL_LSB +: swfcr_pkg::ACK_VAL_W])
                       | (cfg_wdata[swfcr_pkg::ACK_VAL_LSB +: swfcr_pkg::ACK_VAL_W]
                          & wmask[swfcr_pkg::ACK_VAL_LSB +: swfcr_pkg::ACK_VAL_W]); // see RL1
          if (wmask[swfcr_pkg::ACK_EN_BIT]) begin
            next_ack_en = cfg_wdata[swfcr_pkg::ACK_EN_BIT]; // see RL2
          end
        end else if (is_mode(cfg_addr)) begin
          next_mode = (mode & ~wmask[swfcr_pkg::MODE_W-1:0])
                    | (cfg_wdata[swfcr_pkg::MODE_W-1:0] & wmask[swfcr_pkg::MODE_W-1:0]);
        end
      end
      swfcr_pkg::SRC_NONE: begin
        next_mode = mode;
      end
      default: begin
        next_mode = mode;
      end
    endcase
  end

  // register state
  always_ff @(posedge mclk) begin
    if (rst) begin
      ack_val <= swfcr_pkg::ACK_VAL_RST; // see RL1
      ack_en  <= swfcr_pkg::ACK_EN_RST;
      vga     <= swfcr_pkg::VGA_RST; // see RL3
      mode    <= swfcr_pkg::MODE_RST; // see RL6, see RL8
    end else begin
      ack_val <= next_ack_val;
      ack_en  <= next_ack_en;
      vga     <= next_vga;
      mode    <= next_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data, one cycle after the read strobe
  always_comb begin
    next_rdata = '0;
    next_hit   = 1'b0;
    if (cfg_rd) begin
      if (cfg_addr == swfcr_pkg::OFF_ACK_LAT) begin
        next_rdata = ack_word;
        next_hit   = 1'b1;
      end else if (is_mode(cfg_addr)) begin
        next_rdata = mode_word; // see RL5
        next_hit   = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cfg_rdata <= '0;
      cfg_hit   <= 1'b0;
    end else begin
      cfg_rdata <= next_rdata;
      cfg_hit   <= next_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // round-robin arbiter steered by the arbitration mode bit
  always_comb begin
    logic [NPORT-1:0] elig;
    logic             found;
    int               idx;
    next_grant = grant;
    found      = 1'b0;
    idx        = 0;
    elig       = arb_req & arb_credit_ok; // see RL10
    if (mode[swfcr_pkg::ARB_BIT] && |(grant & arb_req)) begin
      next_grant = grant; // see RL9
    end else if (arb_advance || !(|(grant & arb_req))) begin
      next_grant = '0;
      for (int k = 1; k <= NPORT; k++) begin
        idx = 0;
        for (int j = 0; j < NPORT; j++) begin
          if (grant[j]) begin
            idx = (j + k) % NPORT;
          end
        end
        if (!(|grant)) begin
          idx = (k - 1) % NPORT;
        end
        if (!found && elig[idx]) begin
          next_grant[idx] = 1'b1; // see RL10
          found           = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      grant <= '0;
    end else begin
      grant <= next_grant;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  swfcr_ack_sel #(
    .W(swfcr_pkg::ACK_VAL_W)
  ) u_ack_sel (
    .user_val   (ack_val),
    .user_en    (ack_en),
    .builtin_val(builtin_ack),
    .ack_latency(ack_latency)
  );

  swfcr_thr_calc #(
    .LW(LW)
  ) u_thr (
    .pkt_len    (pkt_len),
    .thr_sel    (mode[swfcr_pkg::THR_LSB +: 2]),
    .start_cycle(ct_raw)
  );

  // mode outputs
  assign vga_decode_en    = vga; // see RL3
  assign store_forward    = mode[swfcr_pkg::SF_BIT]; // see RL6
  assign ct_start_cycle   = slow_to_fast ? ct_raw : '0; // see RL7
  assign arb_grant        = grant;
  assign credit_all_types = mode[swfcr_pkg::CRD_BIT]; // see RL11, see RL12
  assign order_egress     = mode[swfcr_pkg::ORD_EGR_BIT]; // see RL13
  assign order_cpl_tag    = mode[swfcr_pkg::ORD_TAG_BIT]; // see RL14

endmodule : swfcr_regs
`default_nettype wire

//--- verif/swfcr_loader.sv
`timescale 1ns/1ps
`default_nettype none

// serial eeprom or side port loading one word at a time
module swfcr_loader (
  // clock
  input  wire logic   mclk,
  // load port toward the registers
  output logic        ld_valid,
  output logic [7:0]  ld_addr,
  output logic [31:0] ld_data
);
  // idle lines at start
  initial begin
    ld_valid = 1'b0;
    ld_addr  = 8'h00;
    ld_data  = 32'h0;
  end
  // one-cycle word load, lines scrambled after release
  task automatic load(input logic [7:0] a, input logic [31:0] d);
    @(negedge mclk);
    ld_valid = 1'b1;
    ld_addr  = a;
    ld_data  = d;
    @(negedge mclk);
    ld_valid = 1'b0;
    ld_addr  = ~a;
    ld_data  = ~d;
  endtask : load
endmodule : swfcr_loader
`default_nettype wire

//--- verif/swfcr_regs_properties.sv
`timescale 1ns/1ps
`default_nettype none

// watches the register bank ports
module swfcr_regs_properties #(
  parameter int NPORT = 6
) (
  // clock, reset, access
  input wire logic             mclk,
  input wire logic             rst,
  input wire logic             cfg_wr,
  input wire logic             cfg_rd,
  input wire logic [7:0]       cfg_addr,
  input wire logic [3:0]       cfg_be,
  input wire logic [31:0]      cfg_wdata,
  input wire logic [31:0]      cfg_rdata,
  input wire logic             cfg_hit,
  // load and mode outputs
  input wire logic             ld_valid,
  input wire logic [7:0]       ld_addr,
  input wire logic [31:0]      ld_data,
  input wire logic [13:0]      builtin_ack,
  input wire logic [13:0]      ack_latency,
  input wire logic             store_forward,
  input wire logic             order_egress,
  input wire logic [NPORT-1:0] arb_grant
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  // access steps
  sequence s_rd70; cfg_rd && cfg_addr == 8'h70; endsequence
  sequence s_rdmap; cfg_rd && (cfg_addr == 8'h70 || cfg_addr == 8'h74); endsequence
  sequence s_sw74; cfg_wr && !ld_valid && cfg_addr == 8'h74 && cfg_be[0]; endsequence
  a_map_rd_hit: assert property (s_rdmap |=> cfg_hit)
    else $error("mapped read without hit");
  a_hit_cause: assert property (cfg_hit |-> $past(cfg_rd))
    else $error("hit without read");
  a_unmap_rd_zero: assert property (cfg_rd && cfg_addr != 8'h70 && cfg_addr != 8'h74
    |=> cfg_rdata == 32'h0 && !cfg_hit)
    else $error("unmapped read answered");
  a_idle_rdata: assert property (!cfg_rd |=> cfg_rdata == 32'h0)
    else $error("read data without read");
  a_user_ack: assert property (s_rd70 ##1 cfg_rdata[30]
    |-> ack_latency == cfg_rdata[29:16])
    else $error("user latency not used");
  a_builtin_ack: assert property (s_rd70 ##1 !cfg_rdata[30]
    |-> ack_latency == builtin_ack)
    else $error("built-in latency not used");
  a_sf_write: assert property (s_sw74 |=> store_forward == $past(cfg_wdata[0]))
    else $error("forwarding mode not written");
  a_egr_write: assert property (s_sw74 |=> order_egress == $past(cfg_wdata[5]))
    else $error("egress ordering not written");
  a_ld_wins: assert property (ld_valid && ld_addr == 8'h74
    |=> store_forward == $past(ld_data[0]))
    else $error("load did not replace mode");
  a_grant_onehot: assert property ($onehot0(arb_grant))
    else $error("grant not one-hot");
endmodule : swfcr_regs_properties
bind swfcr_regs swfcr_regs_properties #(.NPORT(NPORT)) u_props (.mclk(mclk), .rst(rst),
  .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
  .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_hit(cfg_hit), .ld_valid(ld_valid),
  .ld_addr(ld_addr), .ld_data(ld_data), .builtin_ack(builtin_ack),
  .ack_latency(ack_latency), .store_forward(store_forward),
  .order_egress(order_egress), .arb_grant(arb_grant));
`default_nettype wire

//--- verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  // stimulus
  logic        mclk = 1'b0, rst = 1'b1, cfg_wr = 1'b0, cfg_rd = 1'b0;
  logic [7:0]  cfg_addr = 8'h00, ld_addr;
  logic [3:0]  cfg_be = 4'h0;
  logic [31:0] cfg_wdata = 32'h0, cfg_rdata, ld_data;
  logic [13:0] builtin_ack = 14'h0123, ack_latency;
  logic [5:0]  arb_req = 6'h00, arb_credit_ok = 6'h00, arb_grant;
  logic        arb_advance = 1'b0, slow_to_fast = 1'b0;
  logic [10:0] pkt_len = 11'h064, ct_start_cycle;
  // outputs
  logic        cfg_hit, ld_valid, vga_decode_en, store_forward;
  logic        credit_all_types, order_egress, order_cpl_tag;
  int          n_errors = 0, num_checks = 0;
  // clock
  always #10 mclk = ~mclk;
  swfcr_loader ldr (.mclk(mclk), .ld_valid(ld_valid), .ld_addr(ld_addr), .ld_data(ld_data));
  swfcr_regs dut (.mclk(mclk), .rst(rst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .cfg_hit(cfg_hit), .ld_valid(ld_valid), .ld_addr(ld_addr), .ld_data(ld_data),
    .builtin_ack(builtin_ack), .arb_req(arb_req), .arb_credit_ok(arb_credit_ok),
    .arb_advance(arb_advance), .pkt_len(pkt_len), .slow_to_fast(slow_to_fast),
    .ack_latency(ack_latency), .vga_decode_en(vga_decode_en),
    .store_forward(store_forward), .ct_start_cycle(ct_start_cycle), .arb_grant(arb_grant),
    .credit_all_types(credit_all_types), .order_egress(order_egress),
    .order_cpl_tag(order_cpl_tag));
  ////////////////////////////////////////
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(negedge mclk);
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_be = be;
    cfg_wdata = d;
    @(negedge mclk);
    cfg_wr = 1'b0;
    cfg_wdata = ~d;
  endtask : wr
  // read, data judged one cycle later
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(negedge mclk);
    cfg_rd = 1'b1;
    cfg_addr = a;
    @(negedge mclk);
    cfg_rd = 1'b0;
    chk(cfg_rdata, exp);
    chk(32'(cfg_hit), 32'(a == 8'h70 || a == 8'h74));
  endtask : rd
  ////////////////////////////////////////
  task automatic t_ack();
    rd(8'h70, 32'h80000000);
    rd(8'h74, 32'h00000002);
    chk(32'(ack_latency), 32'h0123);
    wr(8'h70, 4'hf, 32'h7fffffff);
    rd(8'h70, 32'hffff0000);
    chk(32'(ack_latency), 32'h3fff);
    wr(8'h70, 4'h4, 32'h0);
    rd(8'h70, 32'hff000000);
  endtask : t_ack
  // each mode bit alone, then all bits
  task automatic t_mode();
    for (int i = 0; i < 7; i++) begin
      wr(8'h74, 4'hf, 32'h1 << i);
      rd(8'h74, 32'h1 << i);
      chk({order_cpl_tag, order_egress, credit_all_types, store_forward},
          {i == 6, i == 5, i == 4, i == 0});
    end
    wr(8'h74, 4'hf, 32'hffffffff);
    rd(8'h74, 32'h0000007f);
    rd(8'h78, 32'h0);
  endtask : t_mode
  // threshold codes on a 100-cycle packet
  task automatic t_thr();
    slow_to_fast = 1'b1;
    for (int t = 0; t < 4; t++) begin
      wr(8'h74, 4'hf, 32'(t) << 1);
      chk(32'(ct_start_cycle), 32'd50 - 32'(t));
    end
    slow_to_fast = 1'b0;
    @(negedge mclk);
    chk(32'(ct_start_cycle), 32'h0);
  endtask : t_thr
  // load beats a software write in the same cycle
  task automatic t_load();
    fork
      ldr.load(8'h74, 32'h1);
      wr(8'h74, 4'hf, 32'h0);
    join
    chk(32'(store_forward), 32'h1);
    ldr.load(8'h70, 32'h0);
    chk(32'(vga_decode_en), 32'h0);
  endtask : t_load
  // mid-run reset restores defaults and clears the grant
  task automatic t_rst();
    @(negedge mclk);
    rst = 1'b1;
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    chk(32'(arb_grant), 32'h0);
    rd(8'h70, 32'h80000000);
    rd(8'h74, 32'h00000002);
  endtask : t_rst
  // arbiter policy, bounded wait for a grant
  task automatic t_arb();
    int i;
    wr(8'h74, 4'hf, 32'h0);
    arb_req = 6'h06;
    arb_credit_ok = 6'h04;
    arb_advance = 1'b1;
    @(negedge mclk);
    arb_advance = 1'b0;
    for (i = 0; i < 20 && arb_grant !== 6'h04; i++) @(negedge mclk);
    chk(32'(arb_grant), 32'h04);
    if (arb_grant !== 6'h04) stop_test();
    wr(8'h74, 4'hf, 32'h8);
    arb_credit_ok = 6'h00;
    arb_advance = 1'b1;
    @(negedge mclk);
    arb_advance = 1'b0;
    repeat (3) @(negedge mclk);
    chk(32'(arb_grant), 32'h04);
  endtask : t_arb
  // main sequence
  initial begin
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    t_ack();
    t_mode();
    t_thr();
    t_arb();
    t_load();
    t_rst();
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
